/* File: wkpc_params.svh */
// Purpose: constants of the wake/kick power control block
// Assumes: included by the package and by design modules
// Notes: offsets are bus addresses on the multiplexed bus
`ifndef WKPC_PARAMS_SVH
`define WKPC_PARAMS_SVH
// register addresses
`define WKPC_REG_A_ADDR 8'h0A
`define WKPC_CTRL_A_ADDR 8'h4A
`define WKPC_CTRL_B_ADDR 8'h4B
`define WKPC_STACK2_ADDR 8'h4E
`define WKPC_STACK3_ADDR 8'h4F
// field positions
`define WKPC_BANK_BIT 4
`define WKPC_REL_BIT 3
`define WKPC_WF_BIT 1
`define WKPC_KF_BIT 0
`define WKPC_HOLD_BIT 3
`define WKPC_WIE_BIT 1
`define WKPC_KSE_BIT 0
// reset values
`define WKPC_REL_RST 1'b0
`define WKPC_FLAG_RST 1'b0
`define WKPC_EN_RST 1'b0
`define WKPC_BANK_RST 1'b0
// stack geometry
`define WKPC_STACK_DEPTH 4
// timing: power-on timeout in seconds and clock rate in hertz
`define WKPC_POTO_S 2
`define WKPC_CLK_HZ 200000000
`define WKPC_POTO_CYCLES (`WKPC_POTO_S * `WKPC_CLK_HZ)
`endif

/* File: wkpc_pkg.sv */
// Purpose: shared types of the wake/kick power control block
// Assumes: constants come from wkpc_params.svh
// Notes: types only
`include "wkpc_params.svh"
package wkpc_pkg;
  typedef logic [7:0] wkpc_byte_t; // one bus byte
  typedef wkpc_byte_t [`WKPC_STACK_DEPTH-1:0] wkpc_stack_t; // entry 0 is newest
endpackage : wkpc_pkg

/* File: wkpc_addr_stack.sv */
// Purpose: push-only stack of latched bus addresses
// Assumes: push is a one-cycle pulse in the clk domain
// Notes: reads never disturb the entries
`timescale 1ns/10ps
`default_nettype none
`include "wkpc_params.svh"
module wkpc_addr_stack
  import wkpc_pkg::*;
(
  input wire logic clk_i, // system clock
  input wire logic rst_b_i, // synchronised reset, active low
  input wire logic ce_i, // clock enable
  input wire logic push_i, // latch pulse
  input wire wkpc_byte_t addr_i, // address to push
  output wkpc_stack_t stack_o // all entries
);
  // entry 0 takes the new address, each deeper entry its neighbour
  for (genvar g = 0; g < `WKPC_STACK_DEPTH; g++) begin : g_entry
    always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        stack_o[g] <= 8'h00;
      end else if (ce_i && push_i) begin
        stack_o[g] <= (g == 0) ? addr_i : stack_o[(g == 0) ? 0 : g - 1];
      end
    end
  end
endmodule : wkpc_addr_stack
`default_nettype wire

/* File: wkpc_top.sv */
// Purpose: wake-up/kickstart power control with address recovery stack
// Assumes: bus pins, supply sense and kick pin are asynchronous
// Notes: open-drain outputs only ever pull low
// Function
// - supply absent, wake enabled: flag sets, power pin low
// - supply returns: interrupt pin also pulls low
// - powered, wake enabled: interrupt and power pin low
// - wake enable off: wake flag drives nothing
// - supply absent, kick enabled: kick pulse powers on
// - powered, kick enabled: interrupt and power pin low
// - kick enable off: kick flag drives nothing
// - stack readable at two bank-one locations
// - address latch fall pushes the stack
// - four entries deep, oldest dropped
// - host latches 0Ah then 4Eh to recover
// - power held on at least two seconds
// - timeout counts only with oscillator running, chain free
// - interrupt and power pins are open drain
// - release bit tristates power; enabled flag clears it
// - hold select keeps power through power fail
// - flags set by event or write one, clear by zero
// - kick flag sets on falling kick input
`timescale 1ns/10ps
`default_nettype none
`include "wkpc_params.svh"
module wkpc_top
  import wkpc_pkg::*;
#(
  parameter int unsigned POTO_CYCLES = `WKPC_POTO_CYCLES // power-on timeout in cycles
) (
  input wire logic clk_i, // 200 MHz clock
  input wire logic rst_b_i, // async reset, active low
  input wire logic ce_i, // clock enable, freezes state when low
  input wire logic [7:0] ad_i, // address/data pins in
  output logic [7:0] ad_o, // read data out
  output logic ad_oe_n_o, // low while driving the data pins
  input wire logic ale_i, // address latch strobe pin
  input wire logic cs_n_i, // chip select pin, active low
  input wire logic rd_n_i, // read strobe pin, active low
  input wire logic wr_n_i, // write strobe pin, active low
  input wire logic kick_in_n_i, // kickstart pin, active low
  input wire logic vcc_ok_i, // main supply present sense
  input wire logic wake_match_i, // alarm match pulse, same clock
  input wire logic other_irq_i, // other enabled interrupt sources
  input wire logic osc_run_i, // oscillator running
  input wire logic chain_reset_i, // countdown chain held in reset
  output logic irq_n_o, // interrupt pin level when pulled
  output logic irq_n_oe_n_o, // low while pulling interrupt low
  output logic power_on_n_o, // power pin level when pulled
  output logic power_on_n_oe_n_o // low while pulling power pin low
);
  logic [1:0] rst_sync; // reset release chain
  logic rst_b; // synchronised reset
  logic [7:0] ad_m, ad_s; // data pin synchroniser
  logic [5:0] pin_m, pin_s; // ale, cs, rd, wr, kick, vcc synchronisers
  logic ale_d, wr_d, kick_d, vcc_d; // delayed copies for edges
  logic ale_fall, wr_rise, kick_fall, vcc_fall; // edge pulses
  logic sel, rd_act; // chip select and read active
  wkpc_stack_t stack; // address stack
  wkpc_byte_t cur_addr; // currently latched address
  logic bank_select; // extended bank select
  logic power_release, power_hold_select; // power controls
  logic wakeup_flag, kick_flag; // event flags
  logic wakeup_irq_enable, kick_irq_enable; // event enables
  logic [31:0] poto_cnt; // power-on timeout counter
  logic en_wake, en_kick, en_any; // enabled flag terms
  logic wr_reg_a, wr_ctrl_a, wr_ctrl_b; // register write strobes
  logic irq_act, pwr_act; // pin pull requests
  wkpc_byte_t next_rdata; // read mux

  // reset is released through two flops
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_b = rst_sync[1];

  // two-flop synchronisers for all pins
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      ad_m <= 8'h00;
      ad_s <= 8'h00;
      pin_m <= 6'h1E;
      pin_s <= 6'h1E;
    end else if (ce_i) begin
      ad_m <= ad_i;
      ad_s <= ad_m;
      pin_m <= {vcc_ok_i, kick_in_n_i, wr_n_i, rd_n_i, cs_n_i, ale_i};
      pin_s <= pin_m;
    end
  end

  // delayed copies for edge detection on synchronised pins
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      ale_d <= 1'b0;
      wr_d <= 1'b1;
      kick_d <= 1'b1;
      vcc_d <= 1'b0;
    end else if (ce_i) begin
      ale_d <= pin_s[0];
      wr_d <= pin_s[3];
      kick_d <= pin_s[4];
      vcc_d <= pin_s[5];
    end
  end
  assign ale_fall = ale_d && !pin_s[0];
  assign wr_rise = !wr_d && pin_s[3];
  assign kick_fall = kick_d && !pin_s[4];
  assign vcc_fall = vcc_d && !pin_s[5];
  assign sel = !pin_s[1];
  assign rd_act = sel && !pin_s[2];

  // address stack, pushed on each latch
  wkpc_addr_stack u_stack (
    .clk_i(clk_i),
    .rst_b_i(rst_b),
    .ce_i(ce_i),
    .push_i(ale_fall),
    .addr_i(ad_s),
    .stack_o(stack)
  );
  assign cur_addr = stack[0];

  // write decode on the write strobe release
  assign wr_reg_a = sel && wr_rise && (cur_addr == `WKPC_REG_A_ADDR);
  assign wr_ctrl_a = sel && wr_rise && bank_select && (cur_addr == `WKPC_CTRL_A_ADDR);
  assign wr_ctrl_b = sel && wr_rise && bank_select && (cur_addr == `WKPC_CTRL_B_ADDR);

  // bank select in register A
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      bank_select <= `WKPC_BANK_RST;
    end else if (ce_i && wr_reg_a) begin
      bank_select <= ad_s[`WKPC_BANK_BIT];
    end
  end

  // enables and hold select in control register B
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      wakeup_irq_enable <= `WKPC_EN_RST;
      kick_irq_enable <= `WKPC_EN_RST;
      power_hold_select <= `WKPC_EN_RST;
    end else if (ce_i && wr_ctrl_b) begin
      wakeup_irq_enable <= ad_s[`WKPC_WIE_BIT];
      kick_irq_enable <= ad_s[`WKPC_KSE_BIT];
      power_hold_select <= ad_s[`WKPC_HOLD_BIT];
    end
  end

  // event flags: an event in the clearing cycle still sets
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      wakeup_flag <= `WKPC_FLAG_RST;
      kick_flag <= `WKPC_FLAG_RST;
    end else if (ce_i) begin
      wakeup_flag <= wake_match_i || (wr_ctrl_a ? ad_s[`WKPC_WF_BIT] : wakeup_flag);
      kick_flag <= kick_fall || (wr_ctrl_a ? ad_s[`WKPC_KF_BIT] : kick_flag);
    end
  end
  assign en_wake = wakeup_flag && wakeup_irq_enable;
  assign en_kick = kick_flag && kick_irq_enable;
  assign en_any = en_wake || en_kick;

  // release bit: enabled flag clears it, power fail without hold sets it
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      power_release <= `WKPC_REL_RST;
    end else if (ce_i) begin
      if (en_any) begin
        power_release <= 1'b0;
      end else if (vcc_fall && !power_hold_select && poto_cnt == 32'h0) begin
        power_release <= 1'b1;
      end else if (wr_ctrl_a) begin
        power_release <= ad_s[`WKPC_REL_BIT];
      end
    end
  end

  // power-on timeout, loaded when an enabled flag finds the release bit set
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      poto_cnt <= 32'h0;
    end else if (ce_i) begin
      if (en_any && poto_cnt == 32'h0 && power_release == 1'b1) begin
        poto_cnt <= POTO_CYCLES[31:0];
      end else if (poto_cnt != 32'h0 && osc_run_i && !chain_reset_i) begin
        poto_cnt <= poto_cnt - 32'h1;
      end
    end
  end

  // pin requests: interrupt only with supply, power per release bit
  assign irq_act = pin_s[5] && (en_any || other_irq_i);
  // an enabled flag pulls the power pin in the cycle it sets, before the release bit clears
  assign pwr_act = !power_release || en_any || (poto_cnt != 32'h0);
  assign irq_n_o = 1'b0;
  assign irq_n_oe_n_o = !irq_act;
  assign power_on_n_o = 1'b0;
  assign power_on_n_oe_n_o = !pwr_act;

  // read mux over the latched address
  always_comb begin
    next_rdata = 8'h00;
    if (cur_addr == `WKPC_REG_A_ADDR) begin
      next_rdata[`WKPC_BANK_BIT] = bank_select;
    end else if (bank_select) begin
      unique case (cur_addr)
        `WKPC_CTRL_A_ADDR: begin
          next_rdata[`WKPC_REL_BIT] = power_release;
          next_rdata[`WKPC_WF_BIT] = wakeup_flag;
          next_rdata[`WKPC_KF_BIT] = kick_flag;
        end
        `WKPC_CTRL_B_ADDR: begin
          next_rdata[`WKPC_HOLD_BIT] = power_hold_select;
          next_rdata[`WKPC_WIE_BIT] = wakeup_irq_enable;
          next_rdata[`WKPC_KSE_BIT] = kick_irq_enable;
        end
        `WKPC_STACK2_ADDR: next_rdata = stack[2];
        `WKPC_STACK3_ADDR: next_rdata = stack[3];
        default: next_rdata = 8'h00; // unmapped reads zero
      endcase
    end
  end

  // read data register, driven while the read strobe is low
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      ad_o <= 8'h00;
    end else if (ce_i) begin
      ad_o <= next_rdata;
    end
  end
  assign ad_oe_n_o = !rd_act;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b);

  wake_sets_flag_a: assert property (ce_i && wake_match_i |=> wakeup_flag)
    else $error("wake match did not set flag");
  kick_sets_flag_a: assert property (ce_i && kick_fall |=> kick_flag)
    else $error("kick edge did not set flag");
  irq_no_supply_a: assert property (!pin_s[5] |-> irq_n_oe_n_o)
    else $error("interrupt pulled without supply");
  irq_wake_on_a: assert property (pin_s[5] && en_wake |-> !irq_n_oe_n_o && !power_on_n_oe_n_o)
    else $error("enabled wake flag not driving pins");
  irq_masked_a: assert property (pin_s[5] && !wakeup_irq_enable && !kick_irq_enable && !other_irq_i
      |-> irq_n_oe_n_o)
    else $error("masked flag pulled interrupt");
  release_clear_a: assert property (ce_i && en_any |=> !power_release && !power_on_n_oe_n_o)
    else $error("enabled flag did not clear release");
  hold_fail_a: assert property (ce_i && vcc_fall && !power_hold_select && !en_any && poto_cnt == 32'h0
      |=> power_release)
    else $error("power not released on power fail");
  stack_push_a: assert property (ce_i && ale_fall |=> stack[1] == $past(stack[0]) && stack[0] == $past(ad_s))
    else $error("stack did not push");
  stack_stable_a: assert property (!(ce_i && ale_fall) |=> $stable(stack))
    else $error("stack changed without latch");
  timeout_hold_a: assert property (poto_cnt != 32'h0 |-> !power_on_n_oe_n_o)
    else $error("power released during timeout");
  timeout_freeze_a: assert property (ce_i && !osc_run_i && !en_any |=> $stable(poto_cnt))
    else $error("timeout counted with oscillator stopped");

  wake_power_c: cover property (ce_i && wake_match_i && wakeup_irq_enable ##1 !power_on_n_oe_n_o);
  kick_power_c: cover property (ce_i && kick_fall && kick_irq_enable && !pin_s[5]);
  stack_push_c: cover property (ale_fall ##[1:20] ale_fall);
  timeout_end_c: cover property (poto_cnt == 32'h1 ##1 poto_cnt == 32'h0);
endmodule : wkpc_top
`default_nettype wire

/* File: wkpc_host_model.sv */
// Purpose: host processor model driving the multiplexed address/data bus
// Assumes: the device synchronises its pins, so each bus phase lasts five clocks
// Notes: once the host lets go of the data lines it shows the inverse of the last value
`timescale 1ns/10ps
`default_nettype none
module wkpc_host_model
  import wkpc_pkg::*;
(
  input wire logic clk_i, // bus clock
  input wire wkpc_byte_t dout_i, // read data from the device
  input wire logic doe_n_i, // device drives the data lines when low
  output logic ale_o, // address latch strobe
  output logic cs_n_o, // chip select, active low
  output logic rd_n_o, // read strobe, active low
  output logic wr_n_o, // write strobe, active low
  output wkpc_byte_t ad_o // address/data towards the device
);
  // idle bus at time zero
  initial begin
    ale_o = 1'b0;
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    ad_o = 8'h00;
  end
  // wait some edges, then move just after the last one
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step
  // address phase: the falling strobe hands the address over
  task automatic latch(input wkpc_byte_t a);
    step(1);
    ad_o = a;
    ale_o = 1'b1;
    step(5);
    ale_o = 1'b0;
    step(5);
  endtask : latch
  // write cycle, data taken when the write strobe rises
  task automatic wr(input wkpc_byte_t a, input wkpc_byte_t d);
    latch(a);
    cs_n_o = 1'b0;
    wr_n_o = 1'b0;
    ad_o = d;
    step(5);
    wr_n_o = 1'b1;
    step(5);
    cs_n_o = 1'b1;
    ad_o = ~d;
    step(5);
  endtask : wr
  // read cycle; unknown data comes back if the device never drives the lines
  task automatic rd(input wkpc_byte_t a, output wkpc_byte_t d);
    int k;
    d = 8'hXX;
    latch(a);
    cs_n_o = 1'b0;
    rd_n_o = 1'b0;
    ad_o = ~a;
    k = 0;
    while (doe_n_i !== 1'b0 && k < 20) begin
      step(1);
      k++;
    end
    step(3);
    if (doe_n_i === 1'b0) d = dout_i;
    rd_n_o = 1'b1;
    cs_n_o = 1'b1;
    step(5);
  endtask : rd
endmodule : wkpc_host_model
`default_nettype wire

/* File: tb.sv */
// Purpose: self-checking bench of the wake/kick power control block
// Assumes: host model on the bus, timeout shortened to twenty clocks
// Notes: table rows cover the enable and supply cases, hand tests follow
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin \
  n_checks++; \
  if ((got) !== (exp)) begin \
    bad_count++; \
    $display("BAD %s exp %h got %h", nm, exp, got); \
  end \
end
module tb;
  import wkpc_pkg::*;
  localparam int unsigned POTO = 20; // shortened power-on timeout
  logic clk_i, rst_b_i, kick_in_n, vcc_ok, wake_match, other_irq, osc_run, chain_reset; // driven inputs
  logic ale, cs_n, rd_n, wr_n, ad_oe_n, irq_n, irq_oe_n, pwr_n, pwr_oe_n; // bus and pins
  wkpc_byte_t ad_h, ad_d, rdat; // bus data
  logic en; // the event's own enable
  logic ce; // clock enable of the block
  int bad_count, n_checks; // counters
  // rows: supply, wake enable, kick enable, kick event, power pin oe_n, interrupt oe_n
  logic [5:0] rows [7] = '{6'b110000, 6'b100011, 6'b010001, 6'b101100, 6'b100111, 6'b001101, 6'b101011};
  wkpc_top #(.POTO_CYCLES(POTO)) wkpc_top_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce),
    .ad_i(ad_h), .ad_o(ad_d), .ad_oe_n_o(ad_oe_n), .ale_i(ale), .cs_n_i(cs_n), .rd_n_i(rd_n),
    .wr_n_i(wr_n), .kick_in_n_i(kick_in_n), .vcc_ok_i(vcc_ok), .wake_match_i(wake_match),
    .other_irq_i(other_irq), .osc_run_i(osc_run), .chain_reset_i(chain_reset), .irq_n_o(irq_n),
    .irq_n_oe_n_o(irq_oe_n), .power_on_n_o(pwr_n), .power_on_n_oe_n_o(pwr_oe_n));
  wkpc_host_model h (.clk_i(clk_i), .dout_i(ad_d), .doe_n_i(ad_oe_n), .ale_o(ale), .cs_n_o(cs_n),
    .rd_n_o(rd_n), .wr_n_o(wr_n), .ad_o(ad_h));
  // 200 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // print counts and verdict, then stop
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc
  // one wake-up match pulse or one low kick pulse
  task automatic fire(input logic kick);
    cyc(1);
    if (kick) kick_in_n = 1'b0;
    else wake_match = 1'b1;
    cyc(kick ? 4 : 1);
    kick_in_n = 1'b1;
    wake_match = 1'b0;
    cyc(8);
  endtask : fire
  // hang guard
  initial begin
    #400000;
    bad_count++;
    summarize();
  end
  initial begin
    bad_count = 0;
    n_checks = 0;
    {rst_b_i, wake_match, other_irq, chain_reset} = 4'h0;
    {kick_in_n, vcc_ok, osc_run, ce} = 4'hF;
    cyc(2);
    `CHK("pwr_rst", 1'b0, pwr_oe_n)
    `CHK("irq_rst", 1'b1, irq_oe_n)
    `CHK("ad_oe_rst", 1'b1, ad_oe_n)
    rst_b_i = 1'b1;
    cyc(6);
    `CHK("od_level", 2'b00, {irq_n, pwr_n})
    h.wr(8'h0A, 8'h10);
    foreach (rows[i]) begin
      vcc_ok = rows[i][5];
      en = rows[i][2] ? rows[i][3] : rows[i][4];
      h.wr(8'h4A, 8'h00);
      h.wr(8'h4B, {6'h00, rows[i][4:3]});
      h.wr(8'h4A, 8'h08);
      cyc(30);
      `CHK("released", 1'b1, pwr_oe_n)
      fire(rows[i][2]);
      `CHK("pwr_ev", rows[i][1], pwr_oe_n)
      `CHK("irq_ev", rows[i][0], irq_oe_n)
      vcc_ok = 1'b1;
      cyc(6);
      `CHK("irq_vcc", ~en, irq_oe_n)
      h.rd(8'h4A, rdat);
      `CHK("flags", {4'h0, ~en, 1'b0, ~rows[i][2], rows[i][2]}, rdat)
    end
    // timer frozen by stopped oscillator or held chain, expiring when both are free
    for (int m = 0; m < 3; m++) begin
      h.wr(8'h4A, 8'h00);
      h.wr(8'h4B, 8'h02);
      h.wr(8'h4A, 8'h08);
      cyc(30);
      osc_run = (m != 0);
      chain_reset = (m == 1);
      fire(1'b0);
      // flags cleared first: a standing enabled flag outranks a release write
      h.wr(8'h4A, 8'h00);
      h.wr(8'h4A, 8'h08);
      cyc(5);
      `CHK("timeout", (m == 2), pwr_oe_n)
      osc_run = 1'b1;
      chain_reset = 1'b0;
      cyc(30);
      `CHK("expiry", 1'b1, pwr_oe_n)
    end
    // power fail with and without hold select
    for (int hs = 1; hs >= 0; hs--) begin
      h.wr(8'h4B, (hs == 1) ? 8'h08 : 8'h00);
      h.wr(8'h4A, 8'h00);
      vcc_ok = 1'b0;
      cyc(8);
      `CHK("hold", (hs == 0), pwr_oe_n)
      vcc_ok = 1'b1;
      cyc(6);
    end
    // frozen clock enable: a wake match is not seen
    ce = 1'b0;
    fire(1'b0);
    ce = 1'b1;
    h.rd(8'h4A, rdat);
    `CHK("ce_freeze", 8'h08, rdat)
    other_irq = 1'b1;
    cyc(3);
    `CHK("other_on", 1'b0, irq_oe_n)
    other_irq = 1'b0;
    cyc(3);
    `CHK("other_off", 1'b1, irq_oe_n)
    // mid-run reset: power pin pulled, interrupt released, bank cleared
    rst_b_i = 1'b0;
    cyc(2);
    `CHK("pwr_rst2", 1'b0, pwr_oe_n)
    `CHK("irq_rst2", 1'b1, irq_oe_n)
    rst_b_i = 1'b1;
    cyc(6);
    h.rd(8'h0A, rdat);
    `CHK("bank_rst", 8'h00, rdat)
    // lost address recovered through the stack
    h.latch(8'h33);
    h.latch(8'h21);
    h.wr(8'h0A, 8'h10);
    h.rd(8'h4E, rdat);
    `CHK("recover", 8'h21, rdat)
    h.rd(8'h4F, rdat);
    `CHK("deep1", 8'h21, rdat)
    h.rd(8'h4F, rdat);
    `CHK("deep2", 8'h0A, rdat)
    h.rd(8'h60, rdat);
    `CHK("unmapped", 8'h00, rdat)
    h.wr(8'h0A, 8'h00);
    h.rd(8'h4E, rdat);
    `CHK("bank_off", 8'h00, rdat)
    summarize();
  end
endmodule : tb
`default_nettype wire
